// ### inc/gia_pkg.sv
// Package: register map, field layout and carriers of the GPIO banks
package gia_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] GIA_BANK_A_SOURCE_OFS = 8'h28;
	localparam logic [7:0] GIA_BANK_A_ENABLE_OFS = 8'h2C;
	localparam logic [7:0] GIA_BANK_A_RESULT_OFS = 8'h30;
	localparam logic [7:0] GIA_BANK_B_SOURCE_OFS = 8'h3C;
	localparam logic [7:0] GIA_BANK_B_ENABLE_OFS = 8'h40;
	localparam logic [7:0] GIA_BANK_B_RESULT_OFS = 8'h44;

	// ==========================================================
	// Field layout
	localparam logic [31:0] GIA_BANK_A_IMPL_MASK = 32'h00FF_FFFF;
	localparam logic [31:0] GIA_BANK_B_IMPL_MASK = 32'h07FF_FFFF;
	localparam int GIA_NORMALIZE_SCRATCH_BIT_BIT = 31;

	// ==========================================================
	// Reset values
	localparam logic [31:0] GIA_REG_RESET = 32'h0000_0000;
	localparam logic GIA_BIT_RESET = 1'h0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} gia_req_t;

	typedef struct packed {
		logic rvalid;
		logic [31:0] rdata;
	} gia_rsp_t;

endpackage

// ### core/gia_aggregator.sv
// GPIO interrupt aggregator: two banks of source, enable and result

// ==========================================================
// One bank
module gia_bank #(
	parameter logic [31:0] IMPL_MASK = 32'h0000_0000
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [31:0] gpio_event,
	input wire logic wr_source,
	input wire logic wr_enable,
	input wire logic wr_result,
	input wire logic [31:0] wdata,
	output logic [31:0] source_r,
	output logic [31:0] enable_r,
	output logic [31:0] result,
	output logic irq_r
);
	import gia_pkg::*;

	logic [31:0] source_nxt;
	logic [31:0] enable_nxt;
	logic [31:0] clear_mask;
	logic [31:0] set_mask;
	logic [31:0] wdata_impl;
	logic [31:0] pending;
	logic normalize_scratch_bit_r;
	logic normalize_scratch_bit_nxt;
	logic irq_nxt;

	// ==========================================================
	// Next-state logic
	// Set wins over clear so an event in the clearing cycle survives
	assign wdata_impl = wdata & IMPL_MASK;
	assign set_mask = gpio_event & IMPL_MASK;
	assign clear_mask = wr_source ? wdata_impl : 32'h0000_0000;
	assign source_nxt = (source_r & ~clear_mask) | set_mask;
	assign enable_nxt = wr_enable ? wdata_impl : enable_r;
	assign normalize_scratch_bit_nxt = wr_result ? wdata[GIA_NORMALIZE_SCRATCH_BIT_BIT] : normalize_scratch_bit_r;
	assign pending = source_r & enable_r & IMPL_MASK;
	assign result = {normalize_scratch_bit_r, pending[30:0]};
	assign irq_nxt = |pending;

	// ==========================================================
	// State
	// One short flop block per register keeps each reset easy to audit
	always_ff @(posedge clock) begin
		if (reset) begin
			source_r <= GIA_REG_RESET;
		end else begin
			source_r <= source_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			enable_r <= GIA_REG_RESET;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			normalize_scratch_bit_r <= GIA_BIT_RESET;
		end else begin
			normalize_scratch_bit_r <= normalize_scratch_bit_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			irq_r <= GIA_BIT_RESET;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_event_sets_bit: assert property (
		|(gpio_event & IMPL_MASK) |=>
		((source_r & $past(gpio_event & IMPL_MASK)) ==
		$past(gpio_event & IMPL_MASK))
	) else $error("event did not set its source bit");

	a_source_sticky: assert property (
		!wr_source |=> ((source_r & $past(source_r)) == $past(source_r))
	) else $error("source bit dropped without a clear");

	a_clear_written_ones: assert property (
		(wr_source && gpio_event == 32'h0000_0000) |=>
		(source_r == ($past(source_r) & ~$past(wdata)))
	) else $error("clear did not remove exactly the written ones");

	a_zero_write_keeps: assert property (
		wr_source |=> ((source_r & ~$past(wdata)) ==
		(($past(source_r) | $past(set_mask)) & ~$past(wdata)))
	) else $error("zero write altered a source bit");

	a_reserved_source: assert property (
		(source_r & ~IMPL_MASK) == 32'h0000_0000
	) else $error("reserved source bit set");

	a_enable_store: assert property (
		wr_enable |=> (enable_r == ($past(wdata) & IMPL_MASK))
	) else $error("enable write not stored");

	a_enable_reserved: assert property (
		(enable_r & ~IMPL_MASK) == 32'h0000_0000
	) else $error("reserved enable bit set");

	a_normalize_scratch_bit_scratch: assert property (
		wr_result |=> (result[31] == $past(wdata[GIA_NORMALIZE_SCRATCH_BIT_BIT]))
	) else $error("scratch bit not stored");

	a_normalize_scratch_bit_hold: assert property (
		!wr_result |=> (result[31] == $past(result[31]))
	) else $error("scratch bit changed without a write");

	a_source_top_zero: assert property (
		source_r[31] == 1'b0
	) else $error("source bit 31 set");

	a_result_and: assert property (
		result[30:0] == (source_r[30:0] & enable_r[30:0])
	) else $error("result is not source and enable");

	a_irq_follows: assert property (
		(|(source_r & enable_r)) |=> irq_r
	) else $error("request not raised for a pending bit");

	a_irq_exact: assert property (
		1'b1 |=> (irq_r == $past(|(source_r & enable_r)))
	) else $error("request does not track pending bits");

	a_reset_clears: assert property (
		@(posedge clock) disable iff (1'b0)
		reset |=> (source_r == 32'h0000_0000 &&
		enable_r == 32'h0000_0000 && result == 32'h0000_0000 && !irq_r)
	) else $error("registers not zero after reset");

	c_event_cleared: cover property (
		(|source_r) ##1 wr_source ##1 (source_r == 32'h0000_0000)
	);
	c_irq_raised: cover property (wr_enable ##[1:8] irq_r);
	c_set_with_clear: cover property (wr_source && (|set_mask));
	c_normalize_scratch_bit_set: cover property (wr_result && wdata[31]);

endmodule

// ==========================================================
// Top: register port and both banks
module gia_aggregator (
	input wire logic clock,
	input wire logic reset,
	input wire gia_pkg::gia_req_t bus_req,
	output gia_pkg::gia_rsp_t bus_rsp,
	input wire logic [31:0] gpio_event_a,
	input wire logic [31:0] gpio_event_b,
	output logic irq_bank_a,
	output logic irq_bank_b
);
	import gia_pkg::*;

	logic [31:0] a_source;
	logic [31:0] a_enable;
	logic [31:0] a_result;
	logic [31:0] b_source;
	logic [31:0] b_enable;
	logic [31:0] b_result;
	logic hit_a_src;
	logic hit_a_en;
	logic hit_a_res;
	logic hit_b_src;
	logic hit_b_en;
	logic hit_b_res;
	logic hit_any;
	logic wr_a_src;
	logic wr_a_en;
	logic wr_a_res;
	logic wr_b_src;
	logic wr_b_en;
	logic wr_b_res;
	logic [31:0] rd_word;
	logic [31:0] rdata_nxt;
	gia_rsp_t rsp_r;
	gia_rsp_t rsp_nxt;

	// ==========================================================
	// Address decode
	assign hit_a_src = bus_req.addr == GIA_BANK_A_SOURCE_OFS;
	assign hit_a_en = bus_req.addr == GIA_BANK_A_ENABLE_OFS;
	assign hit_a_res = bus_req.addr == GIA_BANK_A_RESULT_OFS;
	assign hit_b_src = bus_req.addr == GIA_BANK_B_SOURCE_OFS;
	assign hit_b_en = bus_req.addr == GIA_BANK_B_ENABLE_OFS;
	assign hit_b_res = bus_req.addr == GIA_BANK_B_RESULT_OFS;
	assign hit_any = hit_a_src | hit_a_en | hit_a_res |
		hit_b_src | hit_b_en | hit_b_res;

	// ==========================================================
	// Write strobes
	assign wr_a_src = bus_req.wr && hit_a_src;
	assign wr_a_en = bus_req.wr && hit_a_en;
	assign wr_a_res = bus_req.wr && hit_a_res;
	assign wr_b_src = bus_req.wr && hit_b_src;
	assign wr_b_en = bus_req.wr && hit_b_en;
	assign wr_b_res = bus_req.wr && hit_b_res;

	// Unmapped reads answer zero; unmapped writes are dropped
	assign rdata_nxt = hit_a_src ? a_source :
		hit_a_en ? a_enable :
		hit_a_res ? a_result :
		hit_b_src ? b_source :
		hit_b_en ? b_enable :
		hit_b_res ? b_result : 32'h0000_0000;

	// Idle data is zero so a stale word never looks like an answer
	assign rd_word = bus_req.rd ? rdata_nxt : 32'h0000_0000;
	assign rsp_nxt = {bus_req.rd, rd_word};

	// ==========================================================
	// Banks
	gia_bank #(
		.IMPL_MASK(GIA_BANK_A_IMPL_MASK)
	) u_bank_a (
		.clock(clock),
		.reset(reset),
		.gpio_event(gpio_event_a),
		.wr_source(wr_a_src),
		.wr_enable(wr_a_en),
		.wr_result(wr_a_res),
		.wdata(bus_req.wdata),
		.source_r(a_source),
		.enable_r(a_enable),
		.result(a_result),
		.irq_r(irq_bank_a)
	);

	gia_bank #(
		.IMPL_MASK(GIA_BANK_B_IMPL_MASK)
	) u_bank_b (
		.clock(clock),
		.reset(reset),
		.gpio_event(gpio_event_b),
		.wr_source(wr_b_src),
		.wr_enable(wr_b_en),
		.wr_result(wr_b_res),
		.wdata(bus_req.wdata),
		.source_r(b_source),
		.enable_r(b_enable),
		.result(b_result),
		.irq_r(irq_bank_b)
	);

	// ==========================================================
	// Read response
	always_ff @(posedge clock) begin
		if (reset) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign bus_rsp = rsp_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_rvalid_one_cycle: assert property (
		1'b1 |=> (bus_rsp.rvalid == $past(bus_req.rd))
	) else $error("read answer not one cycle after the read");

	a_rdata_idle_zero: assert property (
		!bus_rsp.rvalid |-> (bus_rsp.rdata == 32'h0000_0000)
	) else $error("read data not zero while idle");

	a_unmapped_read: assert property (
		(bus_req.rd && !hit_any) |=> (bus_rsp.rdata == 32'h0000_0000)
	) else $error("unmapped read did not answer zero");

	a_read_result_b: assert property (
		(bus_req.rd && hit_b_res) |=> (bus_rsp.rdata == $past(b_result))
	) else $error("bank b result read wrong");

	a_reset_response: assert property (
		@(posedge clock) disable iff (1'b0)
		reset |=> (!bus_rsp.rvalid && bus_rsp.rdata == 32'h0000_0000)
	) else $error("read port not idle after reset");

endmodule

// ### testbench/gia_bus_model.sv
// Controller core model: strobe bus master for the register port
module gia_bus_model
	import gia_pkg::*;
(
	input wire logic clock,
	output gia_pkg::gia_req_t bus_req,
	input wire gia_pkg::gia_rsp_t bus_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_req = '0;
	// ==========================================================
	// Released strobes drop and address and data flip, so stale values never pass for valid
	task automatic release_bus();
		bus_req.rd = 1'h0;
		bus_req.wr = 1'h0;
		bus_req.addr = ~bus_req.addr;
		bus_req.wdata = ~bus_req.wdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		bus_req.wr = 1'h1;
		bus_req.addr = a;
		bus_req.wdata = d;
		@(negedge clock);
		release_bus();
	endtask
	// Answer is due one edge after the read is taken
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clock);
		bus_req.rd = 1'h1;
		bus_req.addr = a;
		@(negedge clock);
		d = bus_rsp.rvalid ? bus_rsp.rdata : 32'hDEAD_BEEF;
		release_bus();
	endtask
endmodule

// ### testbench/tb.sv
// Testbench of the two GPIO interrupt banks
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gia_pkg::*;
	logic clock;
	logic reset;
	gia_req_t bus_req;
	gia_rsp_t bus_rsp;
	logic [31:0] ev_a;
	logic [31:0] ev_b;
	logic [31:0] got;
	logic irq_a;
	logic irq_b;
	int fails = 0;
	int check_count = 0;
	gia_aggregator u_dut(.clock(clock), .reset(reset), .bus_req(bus_req),
		.bus_rsp(bus_rsp), .gpio_event_a(ev_a), .gpio_event_b(ev_b),
		.irq_bank_a(irq_a), .irq_bank_b(irq_b));
	gia_bus_model u_bus(.clock(clock), .bus_req(bus_req),
		.bus_rsp(bus_rsp));
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		u_bus.rd(a, got);
		chk(got, e);
	endtask
	task automatic pulse(input logic [31:0] a, input logic [31:0] b);
		@(negedge clock);
		ev_a = a;
		ev_b = b;
		@(negedge clock);
		ev_a = 32'h0000_0000;
		ev_b = 32'h0000_0000;
	endtask
	task automatic end_sim();
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] ofs [7];
		ofs = '{8'h28, 8'h2C, 8'h30, 8'h3C, 8'h40, 8'h44, 8'h34};
		foreach (ofs[i]) rchk(ofs[i], GIA_REG_RESET);
		chk({30'h0, irq_a, irq_b}, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_sticky();
		pulse(32'hFF80_0001, 32'h0000_0000);
		rchk(GIA_BANK_A_SOURCE_OFS, 32'h0080_0001);
		u_bus.wr(GIA_BANK_A_SOURCE_OFS, 32'h0000_0000);
		rchk(GIA_BANK_A_SOURCE_OFS, 32'h0080_0001);
		u_bus.wr(GIA_BANK_A_SOURCE_OFS, 32'hFF00_0001);
		rchk(GIA_BANK_A_SOURCE_OFS, 32'h0080_0000);
		chk({31'h0, irq_a}, 32'h0000_0000);
		$display("test sticky done");
	endtask
	task automatic t_enable();
		u_bus.wr(GIA_BANK_A_ENABLE_OFS, 32'hFFFF_FFFF);
		rchk(GIA_BANK_A_ENABLE_OFS, 32'h00FF_FFFF);
		rchk(GIA_BANK_A_RESULT_OFS, 32'h0080_0000);
		chk({31'h0, irq_a}, 32'h0000_0001);
		u_bus.wr(GIA_BANK_A_RESULT_OFS, 32'hFFFF_FFFF);
		rchk(GIA_BANK_A_RESULT_OFS, 32'h8080_0000);
		u_bus.wr(GIA_BANK_A_SOURCE_OFS, 32'h0080_0000);
		rchk(GIA_BANK_A_RESULT_OFS, 32'h8000_0000);
		chk({31'h0, irq_a}, 32'h0000_0000);
		$display("test enable done");
	endtask
	task automatic t_bank_b();
		u_bus.wr(GIA_BANK_B_ENABLE_OFS, 32'hFFFF_FFFF);
		pulse(32'h0000_0000, 32'hFFFF_FFFF);
		@(negedge clock);
		chk({31'h0, irq_b}, 32'h0000_0001);
		rchk(GIA_BANK_B_SOURCE_OFS, 32'h07FF_FFFF);
		rchk(GIA_BANK_B_ENABLE_OFS, 32'h07FF_FFFF);
		u_bus.wr(GIA_BANK_B_SOURCE_OFS, 32'hFFFF_FFFF);
		rchk(GIA_BANK_B_RESULT_OFS, 32'h0000_0000);
		chk({31'h0, irq_b}, 32'h0000_0000);
		u_bus.wr(GIA_BANK_B_RESULT_OFS, 32'hFFFF_FFFF);
		rchk(GIA_BANK_B_RESULT_OFS, 32'h8000_0000);
		chk({31'h0, irq_b}, 32'h0000_0000);
		$display("test bank b done");
	endtask
	// ==========================================================
	// Clock, watchdog, main sequence
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	// Whole run needs about 100 cycles; far more means a hang
	initial begin
		#100000;
		fails++;
		end_sim();
	end
	initial begin
		reset = 1'h1;
		ev_a = 32'h0000_0000;
		ev_b = 32'h0000_0000;
		repeat (20) @(negedge clock);
		reset = 1'h0;
		t_reset();
		t_sticky();
		t_enable();
		t_bank_b();
		pulse(32'h0000_0001, 32'h0000_0001);
		reset = 1'h1;
		@(negedge clock);
		reset = 1'h0;
		t_reset();
		end_sim();
	end
endmodule
